// ==== core/gpiop_map.vh ====
// Register map, reset values and encodings of the general purpose port.
// Functional notes
// R1 - Eight pins, each direction and latch bit.
// R2 - Direction one makes pin undriven input.
// R3 - Direction zero drives pin from latch.
// R4 - Data read returns live pin levels.
// R5 - Data write loads latch whatever direction.
// R6 - Bit operation uses pin levels, stores latch.
// R7 - Bit operation copies input pins into latch.
// R8 - Write lands at end of cycle.
// R9 - Read samples pins at cycle start.
// R10 - Software spaces write and read apart.
// R11 - Every reset sets all direction bits.
// R12 - Latch undefined cold, kept on warm reset.
// R13 - Pins serve only general purpose I/O.
// R14 - Software clears latch before enabling outputs.
// R15 - Single cycle access, direction reads back.
`ifndef GPIOP_MAP_VH
`define GPIOP_MAP_VH

`define GPIOP_WIDTH        8
`define GPIOP_BANK         4'h8
`define GPIOP_DIR_OFS      8'h12
`define GPIOP_DATA_OFS     8'h13
`define GPIOP_DIR_RESET    8'hff
`define GPIOP_LATCH_COLD   8'h00
`define GPIOP_READ_IDLE    8'h00

`define GPIOP_OP_NONE      2'h0
`define GPIOP_OP_CLEAR     2'h1
`define GPIOP_OP_SET       2'h2
`define GPIOP_OP_TOGGLE    2'h3

`endif

// ==== core/gpiop_port.v ====
// Eight-bit bidirectional general purpose port with direction and latch.
`timescale 1ns/10ps
`default_nettype none
`include "gpiop_map.vh"

module gpiop_port #(
  parameter WIDTH = `GPIOP_WIDTH
) (
  input  wire             i_ref_clk,     // Instruction clock, 40 MHz.
  input  wire             i_reset_n,     // Cold reset (power-on, brownout).
  input  wire             i_warm_reset,  // Sync pin or watchdog reset, high.
  input  wire             i_ce,          // Clock enable, low freezes state.
  input  wire [3:0]       i_bank,        // Selected data bank.
  input  wire [7:0]       i_addr,        // Register offset within bank.
  input  wire             i_rd,          // Register read strobe.
  input  wire             i_wr,          // Register write strobe.
  input  wire [WIDTH-1:0] i_wdata,       // Write data.
  input  wire [1:0]       i_bit_op,      // Bit operation on data register.
  input  wire [2:0]       i_bit_sel,     // Bit index for the bit operation.
  output wire [WIDTH-1:0] o_rdata,       // Read data, registered.
  output wire             o_rd_valid,    // Read data valid pulse.
  input  wire [WIDTH-1:0] i_general_pins,// Pin levels from the pads.
  output wire [WIDTH-1:0] o_general_pins,// Pin drive values.
  output wire [WIDTH-1:0] o_general_oe   // Pin output enables, high drives.
);

  // Map constants resized to the port width, so a wider port pads a reset
  // value or an idle read with zeros and a narrower port cuts it silently.
  localparam [3:0]       PORT_BANK  = `GPIOP_BANK;
  localparam [7:0]       DIR_OFS    = `GPIOP_DIR_OFS;
  localparam [7:0]       DATA_OFS   = `GPIOP_DATA_OFS;
  localparam [WIDTH-1:0] DIR_RESET  = `GPIOP_DIR_RESET;
  localparam [WIDTH-1:0] LATCH_COLD = `GPIOP_LATCH_COLD;
  localparam [WIDTH-1:0] READ_IDLE  = `GPIOP_READ_IDLE;
  localparam [WIDTH-1:0] OE_RESET   = ~DIR_RESET;
  localparam [1:0]       OP_NONE    = `GPIOP_OP_NONE;
  localparam [1:0]       OP_CLEAR   = `GPIOP_OP_CLEAR;
  localparam [1:0]       OP_SET     = `GPIOP_OP_SET;
  localparam [1:0]       OP_TOGGLE  = `GPIOP_OP_TOGGLE;

  // Pin levels after two synchroniser stages. The pads are not timed to
  // the core clock, so the stages are needed; they add two cycles to the
  // time before a pin change can be read back.
  wire [WIDTH-1:0] pins_sync;

  gpiop_sync #(
    .WIDTH (WIDTH)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_ce      (i_ce),
    .i_async   (i_general_pins),
    .o_sync    (pins_sync)
  );

  // Architectural state.
  reg [WIDTH-1:0] pin_direction_reg;
  reg [WIDTH-1:0] pin_direction_next;
  reg [WIDTH-1:0] pin_data_reg;
  reg [WIDTH-1:0] pin_data_next;

  // Output flops.
  reg [WIDTH-1:0] rdata_reg;
  reg [WIDTH-1:0] rdata_next;
  reg             rd_valid_reg;
  reg             rd_valid_next;
  reg [WIDTH-1:0] oe_reg;
  reg [WIDTH-1:0] oe_next;

  // Pin levels latched at the start of the current instruction cycle.
  reg [WIDTH-1:0] pins_start_reg;

  // Address decode inside the bank.
  wire in_bank = (i_bank == PORT_BANK);
  wire hit_dir = in_bank && (i_addr == DIR_OFS);
  wire hit_dat = in_bank && (i_addr == DATA_OFS);

  // Bit mask for the bit operation.
  wire [WIDTH-1:0] bit_mask = {{(WIDTH-1){1'b0}}, 1'b1} << i_bit_sel;

  // Result of a bit operation applied to the sampled pin levels. The
  // operation starts from the pads, not from the latch, because the core
  // reads the port before it modifies and writes it back. A loaded output
  // pin that has not yet reached its level can thus flip its own latch.
  reg [WIDTH-1:0] rmw_value;

  always @* begin
    case (i_bit_op)
      OP_CLEAR: begin
        rmw_value = pins_start_reg & ~bit_mask;      // see R6
      end
      OP_SET: begin
        rmw_value = pins_start_reg | bit_mask;       // see R6
      end
      OP_TOGGLE: begin
        rmw_value = pins_start_reg ^ bit_mask;       // see R6
      end
      default: begin
        rmw_value = pins_start_reg;
      end
    endcase
  end

  // Next-state logic for the registers and the read path.
  always @* begin
    pin_direction_next = pin_direction_reg;
    pin_data_next      = pin_data_reg;
    rdata_next         = READ_IDLE;
    rd_valid_next      = 1'b0;

    // Reads answer in the same instruction cycle. Any address answers
    // with a valid pulse, so the core never waits on an empty slot;
    // offsets outside the port read as zero.
    if (i_rd) begin
      rd_valid_next = 1'b1;                          // see R15
      if (in_bank) begin
        case (i_addr)
          DATA_OFS: begin
            rdata_next = pins_start_reg;             // see R4
          end
          DIR_OFS: begin
            rdata_next = pin_direction_reg;          // see R15
          end
          default: begin
            rdata_next = READ_IDLE;
          end
        endcase
      end
    end

    // Writes land at the closing edge of the cycle, whatever the
    // direction of each pin, so a later switch to output drives the
    // byte that was stored while the pin was still an input.
    if (i_wr && hit_dir) begin
      pin_direction_next = i_wdata;                  // see R15
    end
    if (i_wr && hit_dat) begin
      pin_data_next = i_wdata;                       // see R5 R8
    end

    // A bit operation writes back every bit, so input pins overwrite
    // their latch with whatever level is on the pad. It takes priority
    // over a plain write in the same cycle. Bit operations are decoded
    // on the data register only; the direction register takes whole
    // bytes.
    if (hit_dat && (i_bit_op != OP_NONE)) begin
      pin_data_next = rmw_value;                     // see R7 R8
    end

    // Warm reset forces all pins to inputs but keeps the latch, and it
    // beats any access made in the same cycle.
    if (i_warm_reset) begin
      pin_direction_next = DIR_RESET;                // see R11
      pin_data_next      = pin_data_reg;             // see R12
      rdata_next         = READ_IDLE;
      rd_valid_next      = 1'b0;
    end

    // A one in the direction register releases the pin.
    oe_next = ~pin_direction_next;                   // see R2 R3
  end

  // Pins are sampled at the opening edge of each instruction cycle, so
  // a value written in one cycle cannot be read back in the next three;
  // software must leave three spare cycles for the pad to reach the sample flop.
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pins_start_reg <= READ_IDLE;
    end else if (i_ce) begin
      pins_start_reg <= pins_sync;                   // see R9
    end
  end

  // Architectural registers. The cold latch value is a fixed zero because
  // the latch content is undefined after a cold reset anyway. Software
  // that needs a known level clears the latch before enabling outputs.
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_direction_reg <= DIR_RESET;                // see R11
      pin_data_reg      <= LATCH_COLD;               // see R12
    end else if (i_ce) begin
      pin_direction_reg <= pin_direction_next;
      pin_data_reg      <= pin_data_next;            // see R1
    end
  end

  // Output flops.
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_reg    <= READ_IDLE;
      rd_valid_reg <= 1'b0;
    end else if (i_ce) begin
      rdata_reg    <= rdata_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  // One enable flop per pin. A pad is released from the first moment of a
  // cold reset; a warm reset releases it only at the next enabled clock edge.
  genvar pin;
  generate
    for (pin = 0; pin < WIDTH; pin = pin + 1) begin : g_pin
      always @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          oe_reg[pin] <= OE_RESET[pin];              // see R11
        end else if (i_ce) begin
          oe_reg[pin] <= oe_next[pin];
        end
      end
    end
  endgenerate

  // Every pin is plain I/O; nothing else shares the pads, so the drive
  // value is the latch itself with no output mux in front of it.
  assign o_general_pins = pin_data_reg;              // see R3 R13
  assign o_general_oe   = oe_reg;                    // see R2
  assign o_rdata        = rdata_reg;
  assign o_rd_valid     = rd_valid_reg;

endmodule // gpiop_port

`default_nettype wire

// ==== core/gpiop_sync.v ====
// Two-stage synchroniser for a bus of asynchronous pin levels.
`timescale 1ns/10ps
`default_nettype none

module gpiop_sync #(
  parameter WIDTH = 8
) (
  input  wire             i_ref_clk,  // Core instruction clock.
  input  wire             i_reset_n,  // Asynchronous reset, active low.
  input  wire             i_ce,       // Clock enable, freezes state when low.
  input  wire [WIDTH-1:0] i_async,    // Levels from outside the domain.
  output wire [WIDTH-1:0] o_sync      // Levels safe for logic.
);

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  // One flop pair per pin; the first stage feeds only the second.
  genvar b;
  generate
    for (b = 0; b < WIDTH; b = b + 1) begin : g_bit
      always @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          stage1_reg[b] <= 1'b0;
          stage2_reg[b] <= 1'b0;
        end else if (i_ce) begin
          stage1_reg[b] <= i_async[b];
          stage2_reg[b] <= stage1_reg[b];
        end
      end
    end
  endgenerate

  assign o_sync = stage2_reg;

endmodule // gpiop_sync

`default_nettype wire

// ==== core/README_unused.v ====
// This unit holds no logic of its own.

// ==== verification/gpiop_board.sv ====
// Board model that resolves each port pin from its driver and the wiring.
`timescale 1ns/10ps
`default_nettype none

module gpiop_board (
  input  wire logic [7:0] i_drive,  // Port drive values.
  input  wire logic [7:0] i_oe,     // Port output enables.
  input  wire logic [7:0] i_ext,    // Level the board puts on free pins.
  output var  logic [7:0] o_pad     // Resolved pin levels.
);
  // An enabled pin shows the port's value, a free one the board's.
  always_comb o_pad = (i_drive & i_oe) | (i_ext & ~i_oe);
endmodule // gpiop_board

`default_nettype wire

// ==== verification/gpiop_port_checker.sv ====
// Port-level assertions for the general purpose port.
`timescale 1ns/10ps
`default_nettype none
`include "gpiop_map.vh"

module gpiop_port_checker #(parameter WIDTH = 8) (
  input wire             i_ref_clk,      // Clock.
  input wire             i_reset_n,      // Cold reset.
  input wire             i_warm_reset,   // Warm reset.
  input wire             i_ce,           // Clock enable.
  input wire [3:0]       i_bank,         // Bank.
  input wire [7:0]       i_addr,         // Offset.
  input wire             i_rd,           // Read strobe.
  input wire             i_wr,           // Write strobe.
  input wire [WIDTH-1:0] i_wdata,        // Write data.
  input wire [1:0]       i_bit_op,       // Bit operation.
  input wire [2:0]       i_bit_sel,      // Bit index.
  input wire [WIDTH-1:0] o_rdata,        // Read data.
  input wire             o_rd_valid,     // Read valid.
  input wire [WIDTH-1:0] o_general_pins, // Pin drive.
  input wire [WIDTH-1:0] o_general_oe    // Pin enables.
);
  wire sel = i_ce && i_bank == `GPIOP_BANK;
  wire dir = sel && i_addr == `GPIOP_DIR_OFS;
  wire dat = sel && i_addr == `GPIOP_DATA_OFS;
  wire cold = !i_warm_reset;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  a_dir_write: assert property (dir && i_wr && cold |=>
    o_general_oe == ~$past(i_wdata)) else $error("oe not from dir");
  a_data_write: assert property (dat && i_wr && i_bit_op == 0 && cold
    |=> o_general_pins == $past(i_wdata)) else $error("latch not loaded");
  a_read_pulse: assert property (i_ce && i_rd && cold |=> o_rd_valid)
    else $error("no read valid");
  a_read_idle: assert property (i_ce && !i_rd |=>
    !o_rd_valid && o_rdata == 0) else $error("spurious read data");
  a_warm_reset: assert property (i_ce && i_warm_reset |=>
    o_general_oe == 0 && $stable(o_general_pins)) else $error("warm reset");
  a_unmapped_rd: assert property (i_ce && i_rd && !dir && !dat
    |=> o_rdata == 0) else $error("unmapped read not zero");
  a_dir_read: assert property (dir && i_rd && !i_wr && cold
    |=> o_rdata == ~o_general_oe) else $error("dir readback");
  a_ce_hold: assert property (!i_ce |=> $stable(o_general_oe) &&
    $stable(o_general_pins)) else $error("state moved without enable");
  a_bit_set: assert property (dat && i_bit_op == `GPIOP_OP_SET && cold
    |=> o_general_pins[$past(i_bit_sel)]) else $error("bit not set");
endmodule // gpiop_port_checker

bind gpiop_port gpiop_port_checker #(.WIDTH(WIDTH)) i_gpiop_port_checker (
  .i_ref_clk, .i_reset_n, .i_warm_reset, .i_ce, .i_bank, .i_addr, .i_rd,
  .i_wr, .i_wdata, .i_bit_op, .i_bit_sel, .o_rdata, .o_rd_valid,
  .o_general_pins, .o_general_oe);

`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the general purpose port.
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic       clk = 0, rst_n = 0, warm = 0, ce = 1, rd = 0, wr = 0, rv;
  logic [3:0] bank = 0;
  logic [7:0] addr = 0, wd = 0, ext = 0, rdat, pad, po, oe, lat, p;
  logic [1:0] op = 0;
  logic [2:0] sel = 0;
  int         n_mismatch = 0, cmp_count = 0, cyc = 0;
  gpiop_port i_gpiop_port (.i_ref_clk(clk), .i_reset_n(rst_n),
    .i_warm_reset(warm), .i_ce(ce), .i_bank(bank), .i_addr(addr),
    .i_rd(rd), .i_wr(wr), .i_wdata(wd), .i_bit_op(op), .i_bit_sel(sel),
    .o_rdata(rdat), .o_rd_valid(rv), .i_general_pins(pad),
    .o_general_pins(po), .o_general_oe(oe));
  gpiop_board i_gpiop_board (.i_drive(po), .i_oe(oe), .i_ext(ext),
    .o_pad(pad));
  initial forever #12.5 clk = ~clk;
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Kind 0 reads, 4 writes, 1 to 3 are bit operations; pins settle first.
  task automatic acc(int k, logic [7:0] a, logic [7:0] d = 0,
                     logic [3:0] b = 4'h8);
    repeat (3) @(posedge clk);
    rd <= k == 0;
    wr <= k == 4;
    op <= k[1:0];
    addr <= a;
    wd <= d;
    sel <= d[2:0];
    bank <= b;
    @(posedge clk);
    rd <= 0;
    wr <= 0;
    op <= 0;
    #1;
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic t_reset;
    chk("oe after reset", 8'h00, oe);
    acc(0, 8'h12);
    chk("dir after reset", 8'hff, rdat);
  endtask
  task automatic t_dir_latch;
    acc(4, 8'h13, 8'h00);
    acc(4, 8'h12, 8'h0f);
    chk("oe", 8'hf0, oe);
    acc(0, 8'h12);
    chk("dir readback", 8'h0f, rdat);
    acc(4, 8'h13, 8'ha5);
    chk("latch", 8'ha5, po);
    ext <= 8'h3c;
    acc(0, 8'h13);
    chk("pin read", 8'hac, rdat);
    lat = 8'ha5;
  endtask
  task automatic t_rmw;
    for (int i = 1; i < 4; i++) begin
      ext <= 8'(8'h0f * i);
      p = (lat & 8'hf0) | (8'(8'h0f * i) & 8'h0f);
      lat = i == 1 ? p & ~(8'h01 << 2 * i) : i == 2 ? p | (8'h01 << 2 * i)
            : p ^ (8'h01 << 2 * i);
      acc(i, 8'h13, 8'(2 * i));
      chk("bit operation", lat, po);
    end
  endtask
  task automatic t_warm_unmapped;
    @(posedge clk);
    warm <= 1;
    @(posedge clk);
    warm <= 0;
    ce <= 0;
    wr <= 1;
    addr <= 8'h13;
    wd <= 8'h5a;
    bank <= 4'h8;
    @(posedge clk);
    ce <= 1;
    wr <= 0;
    #1;
    chk("oe warm", 8'h00, oe);
    chk("latch warm", lat, po);
    acc(4, 8'h14, 8'hff);
    chk("unmapped write", lat, po);
    acc(0, 8'h13, 8'h00, 4'h5);
    chk("unmapped read", 8'h00, rdat);
    chk("unmapped valid", 8'h01, {7'h00, rv});
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      report_and_stop;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    t_reset;
    t_dir_latch;
    t_rmw;
    t_warm_unmapped;
    report_and_stop;
  end
endmodule // tb

`default_nettype wire
